// >>> common/dlg_pkg.sv
// Purpose: shared constants for the demodulator loop gain configuration block
// Assumes: 6-bit register addresses, 8-bit register data
// Notes:   gains are given in half-units of the base gain (K, K_I or K_P)
`default_nettype none
package dlg_pkg;
  localparam int unsigned DLG_ADDR_W     = 6;
  localparam int unsigned DLG_DATA_W     = 8;
  // register offsets
  localparam logic [5:0]  DLG_FOC_ADDR   = 6'h19;
  localparam logic [5:0]  DLG_BS_ADDR    = 6'h1A;
  // reset values
  localparam logic [5:0]  DLG_FOC_RESET  = 6'h36;
  localparam logic [7:0]  DLG_BS_RESET   = 8'h6C;
  localparam logic [3:0]  DLG_FOC_GAIN_RESET = 4'h6;
  localparam logic [1:0]  DLG_FOC_LIM_RESET  = 2'h2;
  localparam logic [3:0]  DLG_KI_GAIN_RESET  = 4'h4;
  localparam logic [3:0]  DLG_KP_GAIN_RESET  = 4'h6;
  // freq_offset_comp_config field positions
  localparam int unsigned DLG_FOC_GATE   = 5;
  localparam int unsigned DLG_FOC_PRE_HI = 4;
  localparam int unsigned DLG_FOC_PRE_LO = 3;
  localparam int unsigned DLG_FOC_POST   = 2;
  localparam int unsigned DLG_FOC_LIM_HI = 1;
  localparam int unsigned DLG_FOC_LIM_LO = 0;
  // bit_sync_config field positions
  localparam int unsigned DLG_BS_KI_HI   = 7;
  localparam int unsigned DLG_BS_KI_LO   = 6;
  localparam int unsigned DLG_BS_KP_HI   = 5;
  localparam int unsigned DLG_BS_KP_LO   = 4;
  localparam int unsigned DLG_BS_POST_KI = 3;
  localparam int unsigned DLG_BS_POST_KP = 2;
  localparam int unsigned DLG_BS_LIM_HI  = 1;
  localparam int unsigned DLG_BS_LIM_LO  = 0;
  // fixed post-sync gains in half-units
  localparam logic [3:0]  DLG_HALF_GAIN  = 4'h1;
  localparam logic [3:0]  DLG_UNIT_GAIN  = 4'h2;
endpackage : dlg_pkg
`default_nettype wire

// >>> hdl/dlg_top.sv
// Purpose: register file and loop gain selection for the demodulator loops
// Assumes: all inputs come from logic on sys_clk_in, none from pins
// Notes:   every output is a field of the registered state struct
//
// Overview of operation
// - gate bit freezes both loops until carrier sense
// - pre-sync offset gain K..4K, reset code 2
// - post-sync offset gain same or K/2, reset 1
// - saturation code 0 off, else BW/8, /4, /2
// - pre-sync clock integral gain 1..4 K_I, reset 1
// - pre-sync clock proportional gain K_P..4K_P, reset 2
`timescale 1ns/100ps
`default_nettype none

module dlg_top
  import dlg_pkg::*;
(
  input  wire logic                       sys_clk_in,
  input  wire logic                       rstn_in,
  input  wire logic [dlg_pkg::DLG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [dlg_pkg::DLG_DATA_W-1:0] reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic                       rx_start_in,
  input  wire logic                       carrier_sense_in,
  input  wire logic                       sync_found_in,
  output logic [dlg_pkg::DLG_DATA_W-1:0]  reg_rdata_out,
  output logic                            reg_rvalid_out,
  output logic                            loops_frozen_out,
  output logic [3:0]                      foffset_gain_out,
  output logic [1:0]                      foffset_limit_out,
  output logic                            foffset_enable_out,
  output logic [3:0]                      clkrec_integral_out,
  output logic [3:0]                      clkrec_proportional_out,
  output logic [1:0]                      clkrec_limit_out
);
  import dlg_pkg::*;

  typedef struct packed {
    logic [5:0] foc_cfg;
    logic [7:0] bs_cfg;
    logic       cs_seen;
    logic       frozen;
    logic [3:0] foc_gain;
    logic [1:0] foffset_saturation;
    logic       foc_en;
    logic [3:0] ki_gain;
    logic [3:0] kp_gain;
    logic [1:0] bs_limit;
    logic [7:0] rdata;
    logic       rvalid;
  } dlg_state_s;

  dlg_state_s s;
  dlg_state_s next_s;

  // code n selects (n+1) times the base gain, returned in half-units
  function automatic logic [3:0] dlg_gain_half(input logic [1:0] code);
    logic [2:0] mult;
    mult = {1'b0, code} + 3'h1;
    return {mult, 1'b0};
  endfunction : dlg_gain_half

  always_comb begin
    next_s        = s;
    next_s.rvalid = 1'b0;
    if (reg_wr_in && reg_addr_in == DLG_FOC_ADDR) begin
      next_s.foc_cfg = reg_wdata_in[5:0];
    end
    if (reg_wr_in && reg_addr_in == DLG_BS_ADDR) begin
      next_s.bs_cfg = reg_wdata_in;
    end
    // a new reception re-arms the gate; carrier sense in that same cycle still wins
    if (rx_start_in) begin
      next_s.cs_seen = 1'b0;
    end
    if (carrier_sense_in) begin
      next_s.cs_seen = 1'b1;
    end
    next_s.frozen = next_s.foc_cfg[DLG_FOC_GATE] && !next_s.cs_seen;
    if (sync_found_in && next_s.foc_cfg[DLG_FOC_POST]) begin
      next_s.foc_gain = DLG_HALF_GAIN;
    end else begin
      next_s.foc_gain = dlg_gain_half(next_s.foc_cfg[DLG_FOC_PRE_HI:DLG_FOC_PRE_LO]);
    end
    // hardware bounds the loop only; keeping it off for on-off keying is up to software
    next_s.foffset_saturation = next_s.foc_cfg[DLG_FOC_LIM_HI:DLG_FOC_LIM_LO];
    next_s.foc_en    = next_s.foffset_saturation != 2'b00;
    if (sync_found_in && next_s.bs_cfg[DLG_BS_POST_KI]) begin
      next_s.ki_gain = DLG_HALF_GAIN;
    end else begin
      next_s.ki_gain = dlg_gain_half(next_s.bs_cfg[DLG_BS_KI_HI:DLG_BS_KI_LO]);
    end
    if (sync_found_in && next_s.bs_cfg[DLG_BS_POST_KP]) begin
      next_s.kp_gain = DLG_UNIT_GAIN;
    end else begin
      next_s.kp_gain = dlg_gain_half(next_s.bs_cfg[DLG_BS_KP_HI:DLG_BS_KP_LO]);
    end
    next_s.bs_limit = next_s.bs_cfg[DLG_BS_LIM_HI:DLG_BS_LIM_LO];
    if (reg_rd_in) begin
      next_s.rvalid = 1'b1;
      unique case (reg_addr_in)
        DLG_FOC_ADDR: next_s.rdata = {2'b00, s.foc_cfg};
        DLG_BS_ADDR:  next_s.rdata = s.bs_cfg;
        default:      next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s           <= '0;
      s.foc_cfg   <= DLG_FOC_RESET;
      s.bs_cfg    <= DLG_BS_RESET;
      s.frozen    <= 1'b1;
      s.foc_gain  <= DLG_FOC_GAIN_RESET;
      s.foffset_saturation <= DLG_FOC_LIM_RESET;
      s.foc_en    <= 1'b1;
      s.ki_gain   <= DLG_KI_GAIN_RESET;
      s.kp_gain   <= DLG_KP_GAIN_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out           = s.rdata;
  assign reg_rvalid_out          = s.rvalid;
  assign loops_frozen_out        = s.frozen;
  assign foffset_gain_out        = s.foc_gain;
  assign foffset_limit_out       = s.foffset_saturation;
  assign foffset_enable_out      = s.foc_en;
  assign clkrec_integral_out     = s.ki_gain;
  assign clkrec_proportional_out = s.kp_gain;
  assign clkrec_limit_out        = s.bs_limit;

  default clocking dlg_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  cs_release_a: assert property (carrier_sense_in |=> !loops_frozen_out)
    else $error("loops still frozen after carrier sense");

  gate_hold_a: assert property (
    (rx_start_in && !carrier_sense_in && !reg_wr_in && s.foc_cfg[DLG_FOC_GATE])
    |=> loops_frozen_out ##1 (loops_frozen_out || $past(carrier_sense_in) || $past(reg_wr_in)))
    else $error("loops not frozen while gated");

  gate_off_a: assert property (
    (reg_wr_in && reg_addr_in == DLG_FOC_ADDR && !reg_wdata_in[DLG_FOC_GATE]) |=> !loops_frozen_out)
    else $error("loops frozen with the gate bit cleared");

  gate_idle_a: assert property (
    (!s.foc_cfg[DLG_FOC_GATE] && !(reg_wr_in && reg_addr_in == DLG_FOC_ADDR)) |=> !loops_frozen_out)
    else $error("loops frozen while the gate stays clear");

  foc_pre_a: assert property (
    (!sync_found_in && !reg_wr_in)
    |=> foffset_gain_out == ({2'b00, $past(s.foc_cfg[4:3])} + 4'h1) << 1)
    else $error("pre-sync offset gain wrong");

  foc_post_a: assert property (
    (sync_found_in && !reg_wr_in)
    |=> foffset_gain_out == ($past(s.foc_cfg[2]) ? 4'h1 : ({2'b00, $past(s.foc_cfg[4:3])} + 4'h1) << 1))
    else $error("post-sync offset gain wrong");

  foffset_saturation_a: assert property (
    (reg_wr_in && reg_addr_in == DLG_FOC_ADDR)
    |=> foffset_limit_out == $past(reg_wdata_in[1:0]) && foffset_enable_out == ($past(reg_wdata_in[1:0]) != 2'b00))
    else $error("saturation code not applied");

  limit_keep_a: assert property (
    !(reg_wr_in && reg_addr_in == DLG_FOC_ADDR) |=> $stable(foffset_limit_out) && $stable(foffset_enable_out))
    else $error("saturation code changed without a write");

  clk_ki_a: assert property (
    (!sync_found_in && reg_wr_in && reg_addr_in == DLG_BS_ADDR)
    |=> clkrec_integral_out == ({2'b00, $past(reg_wdata_in[7:6])} + 4'h1) << 1)
    else $error("pre-sync integral gain wrong");

  clk_kp_a: assert property (
    (!sync_found_in && reg_wr_in && reg_addr_in == DLG_BS_ADDR)
    |=> clkrec_proportional_out == ({2'b00, $past(reg_wdata_in[5:4])} + 4'h1) << 1)
    else $error("pre-sync proportional gain wrong");

  ki_post_a: assert property (
    (sync_found_in && !reg_wr_in && s.bs_cfg[DLG_BS_POST_KI]) |=> clkrec_integral_out == DLG_HALF_GAIN)
    else $error("post-sync integral gain wrong");

  kp_post_a: assert property (
    (sync_found_in && !reg_wr_in && s.bs_cfg[DLG_BS_POST_KP]) |=> clkrec_proportional_out == DLG_UNIT_GAIN)
    else $error("post-sync proportional gain wrong");

  bs_limit_a: assert property (
    (reg_wr_in && reg_addr_in == DLG_BS_ADDR) |=> clkrec_limit_out == $past(reg_wdata_in[1:0]))
    else $error("data rate limit code not applied");

  foc_upper_a: assert property (
    (reg_wr_in && reg_addr_in == DLG_FOC_ADDR) ##1 (reg_rd_in && !reg_wr_in && reg_addr_in == DLG_FOC_ADDR)
    |=> reg_rvalid_out && reg_rdata_out == {2'b00, $past(reg_wdata_in[5:0], 2)})
    else $error("offset register readback wrong");

  foc_read_a: assert property (
    (reg_rd_in && reg_addr_in == DLG_FOC_ADDR) |=> reg_rdata_out == {2'b00, $past(s.foc_cfg)})
    else $error("offset register read wrong");

  bs_read_a: assert property (
    (reg_rd_in && reg_addr_in == DLG_BS_ADDR) |=> reg_rdata_out == $past(s.bs_cfg))
    else $error("bit sync register read wrong");

  unmapped_read_a: assert property (
    (reg_rd_in && reg_addr_in != DLG_FOC_ADDR && reg_addr_in != DLG_BS_ADDR) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  read_pulse_a: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");

  read_idle_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read valid without a read");

  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  freeze_release_c: cover property (loops_frozen_out ##[1:20] !loops_frozen_out);
  post_sync_c:      cover property (sync_found_in ##1 foffset_gain_out == 4'h1);
  bs_write_c:       cover property (reg_wr_in && reg_addr_in == DLG_BS_ADDR ##1 reg_rd_in);
  gate_off_c:       cover property (reg_wr_in && reg_addr_in == DLG_FOC_ADDR && !reg_wdata_in[DLG_FOC_GATE]);
  comp_off_c:       cover property (foffset_limit_out == 2'b00 && !foffset_enable_out);
endmodule : dlg_top

`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for dlg_top against a behavioural model
// Assumes: every output follows its cause one clock later
// Notes:   gate bit is random in writes; a second reset lands halfway through the random run
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dlg_pkg::*;
  logic       sys_clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic [5:0] reg_addr_in = '0;
  logic [7:0] reg_wdata_in = '0;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic       rx_start_in = 1'b0;
  logic       carrier_sense_in = 1'b0;
  logic       sync_found_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       reg_rvalid_out;
  logic       loops_frozen_out;
  logic [3:0] foffset_gain_out;
  logic [1:0] foffset_limit_out;
  logic       foffset_enable_out;
  logic [3:0] clkrec_integral_out;
  logic [3:0] clkrec_proportional_out;
  logic [1:0] clkrec_limit_out;
  int         fail_count = 0;
  int         num_checks = 0;
  int         m_foc = int'(DLG_FOC_RESET);
  int         m_bs = int'(DLG_BS_RESET);
  int         m_frz = 1;
  int         m_rv = 0;
  int         m_rd = 0;
  int         m_cs = 0;

  dlg_top i_dut (.sys_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .rx_start_in,
    .carrier_sense_in, .sync_found_in, .reg_rdata_out, .reg_rvalid_out, .loops_frozen_out, .foffset_gain_out,
    .foffset_limit_out, .foffset_enable_out, .clkrec_integral_out, .clkrec_proportional_out, .clkrec_limit_out);

  always #2.5 sys_clk_in = ~sys_clk_in;

  task automatic chk(input string name, input int exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp[7:0]) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp[7:0], got);
    end
  endtask : chk

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // model steps on the inputs sampled at the edge, then compares once outputs settle
  task automatic cyc();
    logic s;
    @(posedge sys_clk_in);
    s = sync_found_in && rstn_in;
    if (!rstn_in) begin
      // reset restores both registers and re-arms the gate
      m_foc = int'(DLG_FOC_RESET);
      m_bs = int'(DLG_BS_RESET);
      m_cs = 0;
      m_rv = 0;
      m_rd = 0;
    end else begin
      m_rv = reg_rd_in;
      if (reg_rd_in) begin
        m_rd = (reg_addr_in == DLG_FOC_ADDR) ? m_foc : (reg_addr_in == DLG_BS_ADDR) ? m_bs : 0;
      end
      if (reg_wr_in && reg_addr_in == DLG_FOC_ADDR) m_foc = reg_wdata_in & 8'h3F;
      if (reg_wr_in && reg_addr_in == DLG_BS_ADDR) m_bs = reg_wdata_in;
      // carrier sense in the same cycle as a new reception still releases the loops
      if (rx_start_in) m_cs = 0;
      if (carrier_sense_in) m_cs = 1;
    end
    m_frz = m_foc[5] && !m_cs;
    #1;
    chk("rvalid", m_rv, reg_rvalid_out);
    chk("rdata", m_rd, reg_rdata_out);
    chk("frozen", m_frz, loops_frozen_out);
    chk("foffset_gain", (s && m_foc[2]) ? 1 : 2 * (((m_foc >> 3) & 3) + 1), foffset_gain_out);
    chk("foffset_limit", m_foc & 3, foffset_limit_out);
    chk("foffset_enable", (m_foc & 3) != 0, foffset_enable_out);
    chk("clkrec_integral", (s && m_bs[3]) ? 1 : 2 * (((m_bs >> 6) & 3) + 1), clkrec_integral_out);
    chk("clkrec_prop", (s && m_bs[2]) ? 2 : 2 * (((m_bs >> 4) & 3) + 1), clkrec_proportional_out);
    chk("clkrec_limit", m_bs & 3, clkrec_limit_out);
  endtask : cyc

  initial begin
    void'($urandom(32'h6B533625));
    repeat (20) cyc();
    rstn_in = 1'b1;
    // on-off keying: the host clears the saturation code, compensation must drop out
    reg_addr_in = DLG_FOC_ADDR;
    reg_wdata_in = 8'($urandom) & 8'hFC;
    reg_wr_in = 1'b1;
    cyc();
    chk("ook_enable", 0, foffset_enable_out);
    // random 6-bit addresses a quarter of the time, back-to-back strobes allowed
    for (int i = 0; i < 4000; i++) begin
      if (i == 2000) begin
        // a second reset halfway must bring back the reset configuration and the gate
        rstn_in = 1'b0;
        repeat (4) cyc();
        rstn_in = 1'b1;
      end
      reg_addr_in = ($urandom % 4 == 0) ? 6'($urandom) : (($urandom % 2 == 0) ? DLG_FOC_ADDR : DLG_BS_ADDR);
      reg_wdata_in = 8'($urandom);
      reg_wr_in = 1'($urandom);
      reg_rd_in = 1'($urandom);
      rx_start_in = ($urandom % 6 == 0);
      carrier_sense_in = ($urandom % 8 == 0);
      if ($urandom % 12 == 0) sync_found_in = ~sync_found_in;
      cyc();
    end
    finish_test();
  end

  initial begin
    #50000;
    fail_count++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
